// ===== core/scp_pkg.sv
// Constants and types for the serial configuration command port
package scp_pkg;
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_ENTER = 8'h2A;
  localparam logic [7:0] CMD_LEAVE = 8'h3A;
  localparam logic [7:0] CMD_CLEAR = 8'hD0;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hEA;
  localparam logic [2:0] OPC_WRITE = 3'h4;
  localparam logic [2:0] OPC_READ = 3'h5;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_SEED = 8'hFF;
  localparam int CFG_REGS = 30;
  localparam int REMOTE_FIRST = 16;
  localparam logic [4:0] ADDR_STATUS_TWO = 5'h1E;
  localparam logic [4:0] ADDR_STATUS_THREE = 5'h1F;
  localparam int CRC_EN_REG = 0;
  localparam int CRC_EN_BIT = 0;
  localparam logic [7:0] CFG_DEFAULT = 8'h00;
  localparam int ST_CFG_BIT = 0;
  localparam int ST_REGERR_BIT = 1;
  localparam int ST_COMERR_BIT = 2;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CFG_TIME_NS = 50_000_000;
  localparam int CFG_TIMEOUT_CYC = CFG_TIME_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 24;
  typedef enum logic {WR_IDLE = 1'b0, WR_DATA = 1'b1} scp_wr_type;
  typedef enum logic [1:0] {PEND_NONE = 2'h0, PEND_READ = 2'h1, PEND_CLEAR = 2'h3} scp_pend_type;
endpackage

// ===== core/scp_spi_config_command_port.sv
// Serial command port: link shifter, frame check, command decode, configuration mode
module scp_spi_config_command_port
  import scp_pkg::*;
#(
  parameter int CFG_TIMEOUT_CYCLES = CFG_TIMEOUT_CYC
) (
  input wire logic clk, // System clock, 40 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic clkEn, // Freezes system-side state while low
  input wire logic spiClk, // Serial clock from host
  input wire logic csN, // Chip select, active low
  input wire logic sdi, // Serial data in
  output logic sdo, // Serial data out
  input wire logic shutdownN, // Shutdown pin level, low stops switching
  input wire logic hvPowered, // High-voltage side powered
  input wire logic hwStopState, // Device is in hardware stop state
  output logic cfgMode, // Configuration mode active
  output logic cfgFlagLow, // Low-side configuration-mode flag
  output logic cfgFlagHigh, // High-side configuration-mode flag
  output logic commErr, // Communication error flag
  output logic regFaultLow, // Low-side register corruption flag
  output logic regFaultHigh, // High-side register corruption flag
  output logic safeStateReq, // Request to force the safe state
  output logic crcEnable, // Received CRC checking enabled
  output logic [CFG_REGS-1:0][7:0] cfgActive // Active configuration registers
);
  typedef struct packed {
    logic csMeta;
    logic csSync;
    logic csPrev;
    logic sdMeta;
    logic sdSync;
    logic sdPrev;
    logic cfgMode;
    logic cfgFlagLow;
    logic cfgFlagHigh;
    logic commErr;
    logic regFaultLow;
    logic regFaultHigh;
    logic safeStateReq;
    logic softPend;
    scp_wr_type wrState;
    logic [4:0] wrAddr;
    logic [7:0] cmdCrc;
    scp_pend_type pend;
    logic [4:0] pendAddr;
    logic [TMR_W-1:0] timer;
    logic [15:0] respWord;
    logic [CFG_REGS-1:0][7:0] active;
    logic [CFG_REGS-1:0][7:0] check;
    logic [CFG_REGS-1:0][7:0] shadow;
  } scp_state_type;

  scp_state_type r;
  scp_state_type n;

  // Link side, clocked by the host serial clock
  logic armedLk;
  logic wrapLk;
  logic [3:0] edgeCntLk;
  logic [15:0] rxLk;
  logic sdoLk;
  // Frame verdict, clocked by the chip-select rise
  logic endSeenLk;
  logic endOkLk;

  function automatic logic [7:0] crcByte(input logic [7:0] seed, input logic [7:0] data);
    logic [7:0] c;
    c = seed;
    for (int i = 7; i >= 0; i--) begin
      if (c[7] ^ data[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  // Chip select high re-arms the frame; counters stay readable until the next frame's first edge
  always_ff @(posedge spiClk or posedge csN) begin
    if (csN) begin
      armedLk <= 1'b1;
      sdoLk <= 1'b0;
    end else if (armedLk) begin
      // First edge of a frame: restart the count and start our response
      armedLk <= 1'b0;
      edgeCntLk <= 4'h1;
      wrapLk <= 1'b0;
      sdoLk <= r.respWord[15];
    end else begin
      edgeCntLk <= edgeCntLk + 4'h1;
      if (edgeCntLk == 4'hF) begin
        wrapLk <= 1'b1;
      end
      // After our own word, pass the delayed input on to the next device
      sdoLk <= wrapLk ? rxLk[15] : r.respWord[4'hF - edgeCntLk];
    end
  end

  always_ff @(negedge spiClk) begin
    rxLk <= {rxLk[14:0], sdi};
  end

  // Taken at the chip-select rise, before the re-arm hides whether the frame had edges;
  // it then stands for the system side until the next frame ends
  always_ff @(posedge csN) begin
    endSeenLk <= ~armedLk;
    endOkLk <= ~armedLk & wrapLk & (edgeCntLk == 4'h0);
  end

  assign sdo = sdoLk;

  logic frameEnd;
  logic frameOk;
  logic [7:0] byteHi;
  logic [7:0] byteLo;
  logic crcOn;
  logic setErr;
  logic clrFlags;
  logic doRead;
  logic [4:0] readAddr;
  logic doClear;
  logic abortCfg;
  logic commit;
  logic missLow;
  logic missHigh;
  logic [7:0] readData;

  always_comb begin
    n = r;
    setErr = 1'b0;
    clrFlags = 1'b0;
    doRead = 1'b0;
    readAddr = 5'h00;
    doClear = 1'b0;
    abortCfg = 1'b0;
    commit = 1'b0;
    missLow = 1'b0;
    missHigh = 1'b0;
    readData = 8'h00;
    n.csMeta = csN;
    n.csSync = r.csMeta;
    n.csPrev = r.csSync;
    n.sdMeta = shutdownN;
    n.sdSync = r.sdMeta;
    n.sdPrev = r.sdSync;
    crcOn = r.active[CRC_EN_REG][CRC_EN_BIT];
    byteHi = rxLk[15:8];
    byteLo = rxLk[7:0];
    // Link words and the verdict stand still while chip select is high; the synchronised
    // rise is seen well inside the host's deselect time, before the next frame can start
    frameEnd = r.csSync & ~r.csPrev & endSeenLk;
    frameOk = endOkLk;

    // Buffered command goes out once the high side is back
    if (hvPowered && r.pend != PEND_NONE) begin
      if (r.pend == PEND_READ) begin
        doRead = 1'b1;
        readAddr = r.pendAddr;
      end else begin
        doClear = 1'b1;
      end
      n.pend = PEND_NONE;
    end

    if (frameEnd) begin
      if (!frameOk) begin
        setErr = 1'b1;
      end else if (r.wrState == WR_DATA) begin
        n.wrState = WR_IDLE;
        if (crcOn && byteLo != ~crcByte(r.cmdCrc, byteHi)) begin
          setErr = 1'b1;
        end else if (r.cfgMode && r.wrAddr < 5'(CFG_REGS)) begin
          n.shadow[r.wrAddr] = byteHi;
        end else begin
          setErr = 1'b1;
        end
      end else if (crcOn && byteLo != ~crcByte(CRC_SEED, byteHi)) begin
        setErr = 1'b1;
      end else if (byteHi[7:5] == OPC_WRITE) begin
        if (r.cfgMode) begin
          n.wrState = WR_DATA;
          n.wrAddr = byteHi[4:0];
          n.cmdCrc = crcByte(CRC_SEED, byteHi);
        end else begin
          setErr = 1'b1;
        end
      end else if (byteHi[7:5] == OPC_READ) begin
        if (byteHi[4:0] >= 5'(REMOTE_FIRST) && !hvPowered) begin
          n.pend = PEND_READ;
          n.pendAddr = byteHi[4:0];
        end else begin
          doRead = 1'b1;
          readAddr = byteHi[4:0];
        end
      end else begin
        case (byteHi)
          CMD_NOP: begin
            n.respWord = r.respWord;
          end
          CMD_CLEAR: begin
            if (r.sdSync) begin
              setErr = 1'b1;
            end else if (hvPowered) begin
              doClear = 1'b1;
            end else begin
              n.pend = PEND_CLEAR;
            end
          end
          CMD_ENTER: begin
            if (r.sdSync) begin
              setErr = 1'b1;
            end else begin
              n.cfgMode = 1'b1;
              n.cfgFlagLow = 1'b1;
              n.cfgFlagHigh = 1'b1;
              n.timer = '0;
              n.shadow = r.active;
              n.softPend = 1'b0;
            end
          end
          CMD_LEAVE: begin
            if (r.sdSync) begin
              setErr = 1'b1;
            end else if (r.cfgMode) begin
              commit = 1'b1;
            end
          end
          CMD_SOFT_RESET: begin
            if (r.cfgMode) begin
              n.softPend = 1'b1;
            end else begin
              setErr = 1'b1;
            end
          end
          default: begin
            setErr = 1'b1;
          end
        endcase
      end
    end

    // Timer runs only in configuration mode; shutdown rising aborts at once
    if (r.cfgMode) begin
      n.timer = r.timer + TMR_W'(1);
      if (r.sdSync && !r.sdPrev) begin
        abortCfg = 1'b1;
      end else if (r.timer >= TMR_W'(CFG_TIMEOUT_CYCLES - 1) && !commit) begin
        abortCfg = 1'b1;
      end
    end
    if (abortCfg) begin
      setErr = 1'b1;
      n.cfgMode = 1'b0;
      n.wrState = WR_IDLE;
      n.softPend = 1'b0;
      n.shadow = r.active;
    end

    if (commit) begin
      n.cfgMode = 1'b0;
      n.cfgFlagLow = 1'b0;
      n.cfgFlagHigh = 1'b0;
      n.wrState = WR_IDLE;
      n.softPend = 1'b0;
      if (r.softPend) begin
        n.active = {CFG_REGS{CFG_DEFAULT}};
        clrFlags = 1'b1;
      end else begin
        n.active = r.shadow;
      end
      n.check = ~n.active;
    end

    // Every active register has an inverted twin; disagreement means corruption
    for (int i = 0; i < CFG_REGS; i++) begin
      if (r.active[i] != ~r.check[i]) begin
        if (i < REMOTE_FIRST) begin
          missLow = 1'b1;
        end else begin
          missHigh = 1'b1;
        end
      end
    end

    if (doClear) begin
      clrFlags = 1'b1;
    end

    // Set wins over clear; a fault still present survives the clear
    n.commErr = (r.commErr & ~clrFlags) | setErr;
    n.regFaultLow = (r.regFaultLow & ~clrFlags) | missLow;
    n.regFaultHigh = (r.regFaultHigh & ~clrFlags) | missHigh;
    n.safeStateReq = n.regFaultHigh | (n.regFaultLow & ~hwStopState);

    if (doRead) begin
      if (readAddr == ADDR_STATUS_TWO) begin
        readData[ST_CFG_BIT] = r.cfgFlagHigh;
        readData[ST_REGERR_BIT] = r.regFaultHigh;
      end else if (readAddr == ADDR_STATUS_THREE) begin
        readData[ST_CFG_BIT] = r.cfgFlagLow;
        readData[ST_REGERR_BIT] = r.regFaultLow;
        readData[ST_COMERR_BIT] = r.commErr;
      end else if (readAddr < 5'(CFG_REGS)) begin
        readData = r.active[readAddr];
      end
      n.respWord = {readData, crcByte(CRC_SEED, readData)};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
      r.csMeta <= 1'b1;
      r.csSync <= 1'b1;
      r.csPrev <= 1'b1;
      // Shutdown synchroniser idles high so a pin held high gives no false rise after reset
      r.sdMeta <= 1'b1;
      r.sdSync <= 1'b1;
      r.sdPrev <= 1'b1;
      r.wrState <= WR_IDLE;
      r.pend <= PEND_NONE;
      r.respWord <= {8'h00, crcByte(CRC_SEED, 8'h00)};
      r.active <= {CFG_REGS{CFG_DEFAULT}};
      r.check <= ~{CFG_REGS{CFG_DEFAULT}};
      r.shadow <= {CFG_REGS{CFG_DEFAULT}};
    end else if (clkEn) begin
      r <= n;
    end
  end

  assign cfgMode = r.cfgMode;
  assign cfgFlagLow = r.cfgFlagLow;
  assign cfgFlagHigh = r.cfgFlagHigh;
  assign commErr = r.commErr;
  assign regFaultLow = r.regFaultLow;
  assign regFaultHigh = r.regFaultHigh;
  assign safeStateReq = r.safeStateReq;
  assign crcEnable = r.active[CRC_EN_REG][CRC_EN_BIT];
  assign cfgActive = r.active;
endmodule

// ===== verif/scp_spi_config_command_port_properties.sv
// Assertions for the serial configuration command port
module scp_spi_config_command_port_properties
  import scp_pkg::*;
#(
  parameter int CFG_TIMEOUT_CYCLES = CFG_TIMEOUT_CYC
) (
  input wire logic clk, // Clock
  input wire logic reset, // Reset
  input wire logic clkEn, // Enable
  input wire logic csN, // Select
  input wire logic sdo, // Data out
  input wire logic shutdownN, // Shutdown pin
  input wire logic cfgMode, // Config mode
  input wire logic cfgFlagLow, // Low flag
  input wire logic cfgFlagHigh, // High flag
  input wire logic commErr, // Error flag
  input wire logic regFaultHigh, // Fault flag
  input wire logic safeStateReq, // Safe request
  input wire logic crcEnable, // CRC on
  input wire logic [CFG_REGS-1:0][7:0] cfgActive // Active config
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [31:0] cfgCount_reg;
  always_ff @(posedge clk) begin
    if (reset || !cfgMode) cfgCount_reg <= 32'h0000_0000;
    else if (clkEn) cfgCount_reg <= cfgCount_reg + 32'h0000_0001;
  end
  sequence s_enter; $rose(cfgMode); endsequence
  sequence s_abort; $fell(cfgMode) && cfgFlagLow; endsequence
  property p_enter_flags; s_enter |-> ##[0:1] (cfgFlagLow && cfgFlagHigh); endproperty
  a_enter_flags: assert property (p_enter_flags) else $error("mode flags not set on entry");
  property p_sd_abort; shutdownN [*6] |-> !cfgMode; endproperty
  a_sd_abort: assert property (p_sd_abort) else $error("config mode with shutdown high");
  property p_abort_err; s_abort |-> ##[0:1] commErr; endproperty
  a_abort_err: assert property (p_abort_err) else $error("abort without error flag");
  property p_leave_clear; $fell(cfgFlagLow) |-> $past(cfgMode); endproperty
  a_leave_clear: assert property (p_leave_clear) else $error("mode flag cleared outside mode");
  property p_commit; $changed(cfgActive) |-> $fell(cfgMode); endproperty
  a_commit: assert property (p_commit) else $error("active config changed outside commit");
  property p_crc; $changed(crcEnable) |-> $fell(cfgMode) && !cfgFlagLow; endproperty
  a_crc: assert property (p_crc) else $error("crc enable changed outside a commit");
  property p_timer; cfgCount_reg <= CFG_TIMEOUT_CYCLES + 4; endproperty
  a_timer: assert property (p_timer) else $error("config timer overrun");
  property p_sdo_idle; csN |-> !sdo; endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("sdo active while deselected");
  property p_safe; regFaultHigh |-> safeStateReq; endproperty
  a_safe: assert property (p_safe) else $error("no safe request on fault");
endmodule
bind scp_spi_config_command_port scp_spi_config_command_port_properties #(
  .CFG_TIMEOUT_CYCLES(CFG_TIMEOUT_CYCLES)
) scp_spi_config_command_port_properties_i (
  .clk(clk), .reset(reset), .clkEn(clkEn), .csN(csN), .sdo(sdo), .shutdownN(shutdownN),
  .cfgMode(cfgMode), .cfgFlagLow(cfgFlagLow), .cfgFlagHigh(cfgFlagHigh), .commErr(commErr),
  .regFaultHigh(regFaultHigh), .safeStateReq(safeStateReq), .crcEnable(crcEnable), .cfgActive(cfgActive)
);

// ===== verif/scp_host_model.sv
// Host controller model driving the serial link
module scp_host_model (
  output logic spiClk, // Serial clock
  output logic csN, // Chip select
  output logic sdi, // Data to device
  input wire logic sdo // Data from device
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rx;
  initial begin
    spiClk = 1'b0;
    sdi = 1'b0;
    // Rise after time zero so the device always sees a clean re-arm edge
    #1 csN = 1'b1;
  end
  function automatic logic [7:0] crc8(logic [7:0] seed, logic [7:0] b);
    logic [7:0] c;
    c = seed;
    for (int i = 7; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic frame(logic [15:0] w, int n);
    #1 csN = 1'b0; // Clock low at select
    #3;
    for (int i = 0; i < n; i++) begin
      spiClk = 1'b1;
      sdi = w[15 - i % 16]; // Change on rising edge
      #3 spiClk = 1'b0;
      rx = {rx[14:0], sdo};
      #3;
    end
    csN = 1'b1;
    sdi = ~sdi;
    #400; // Deselect time
  endtask
  task automatic cmd(logic [7:0] b, logic bad);
    frame({b, ~crc8(8'hFF, b) ^ {7'h00, bad}}, 16);
  endtask
  task automatic wr(logic [4:0] a, logic [7:0] d);
    logic [7:0] c;
    c = crc8(8'hFF, {3'h4, a});
    frame({3'h4, a, ~c}, 16);
    frame({d, ~crc8(c, d)}, 16);
  endtask
endmodule

// ===== verif/scp_spi_config_command_port_tb.sv
// Testbench for the serial configuration command port
module scp_spi_config_command_port_tb
  import scp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TMO = 200;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clkEn = 1'b1;
  logic shutdownN = 1'b1;
  logic hvPowered = 1'b1;
  logic hwStopState = 1'b0;
  logic spiClk, csN, sdi, sdo, cfgMode, cfgFlagLow, cfgFlagHigh, commErr;
  logic regFaultLow, regFaultHigh, safeStateReq, crcEnable;
  logic [CFG_REGS-1:0][7:0] cfgActive;
  int fails = 0;
  int comparisons = 0;
  always #12.5 clk = ~clk;
  scp_spi_config_command_port #(.CFG_TIMEOUT_CYCLES(TMO)) scp_spi_config_command_port_i (
    .clk(clk), .reset(reset), .clkEn(clkEn), .spiClk(spiClk), .csN(csN), .sdi(sdi), .sdo(sdo),
    .shutdownN(shutdownN), .hvPowered(hvPowered), .hwStopState(hwStopState), .cfgMode(cfgMode),
    .cfgFlagLow(cfgFlagLow), .cfgFlagHigh(cfgFlagHigh), .commErr(commErr), .regFaultLow(regFaultLow),
    .regFaultHigh(regFaultHigh), .safeStateReq(safeStateReq), .crcEnable(crcEnable), .cfgActive(cfgActive)
  );
  scp_host_model scp_host_model_i (.spiClk(spiClk), .csN(csN), .sdi(sdi), .sdo(sdo));
  task automatic chkFlag(string n, logic e, logic g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chkWord(string n, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize;
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic pins(logic sd, logic hv);
    @(negedge clk);
    shutdownN = sd;
    hvPowered = hv;
    repeat (8) @(negedge clk);
  endtask
  task automatic send(logic [7:0] b, logic bad = 1'b0);
    scp_host_model_i.cmd(b, bad);
  endtask
  function automatic logic [15:0] resp(logic [7:0] d);
    return {d, scp_host_model_i.crc8(8'hFF, d)};
  endfunction
  task automatic readBack(logic [4:0] a, logic [7:0] d);
    send({OPC_READ, a});
    send(CMD_NOP);
    chkWord("read response", resp(d), scp_host_model_i.rx);
  endtask
  initial begin
    repeat (3) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    chkFlag("crcEnable", 1'b0, crcEnable);
    readBack(5'h05, 8'h00);
    pins(1'b0, 1'b1);
    scp_host_model_i.frame(16'h0000, 8);
    chkFlag("short frame", 1'b1, commErr);
    send(CMD_CLEAR);
    chkFlag("clear", 1'b0, commErr);
    pins(1'b1, 1'b1);
    send(CMD_CLEAR);
    chkFlag("clear refused", 1'b1, commErr);
    pins(1'b0, 1'b1);
    send(CMD_CLEAR);
    pins(1'b1, 1'b1);
    send(CMD_ENTER);
    chkFlag("enter refused", 1'b1, commErr);
    chkFlag("cfgMode", 1'b0, cfgMode);
    pins(1'b0, 1'b1);
    send(CMD_CLEAR);
    scp_host_model_i.wr(5'h05, 8'h77);
    chkFlag("write refused", 1'b1, commErr);
    send(CMD_CLEAR);
    send(CMD_ENTER);
    chkFlag("cfgFlagHigh", 1'b1, cfgFlagHigh);
    scp_host_model_i.wr(5'h05, 8'hA5);
    scp_host_model_i.wr(5'h00, 8'h01);
    chkWord("shadow held", 16'h0000, {8'h00, cfgActive[5]});
    send(CMD_LEAVE);
    chkWord("commit", 16'h00A5, {8'h00, cfgActive[5]});
    chkFlag("cfgFlagLow", 1'b0, cfgFlagLow);
    chkFlag("crcEnable on", 1'b1, crcEnable);
    send({OPC_READ, 5'h05}, 1'b1);
    chkFlag("bad crc", 1'b1, commErr);
    send(CMD_NOP);
    chkWord("ignored read", resp(8'h00), scp_host_model_i.rx);
    send(CMD_CLEAR);
    readBack(5'h05, 8'hA5);
    send(CMD_ENTER);
    scp_host_model_i.wr(5'h05, 8'h3C);
    pins(1'b1, 1'b1);
    chkFlag("abort", 1'b0, cfgMode);
    chkFlag("abort error", 1'b1, commErr);
    chkWord("kept", 16'h00A5, {8'h00, cfgActive[5]});
    pins(1'b0, 1'b1);
    send(CMD_CLEAR);
    send(CMD_ENTER);
    for (int i = 0; i < TMO + 50 && cfgMode !== 1'b0; i++) @(negedge clk);
    chkFlag("timeout", 1'b0, cfgMode);
    if (cfgMode !== 1'b0) summarize();
    chkFlag("timeout flags", 1'b1, cfgFlagLow & commErr);
    readBack(ADDR_STATUS_THREE, 8'h05);
    readBack(ADDR_STATUS_TWO, 8'h01);
    send(CMD_CLEAR);
    send(CMD_ENTER);
    send(CMD_SOFT_RESET);
    chkFlag("crc kept", 1'b1, crcEnable);
    send(CMD_LEAVE);
    chkWord("soft reset", 16'h0000, {8'h00, cfgActive[5]});
    chkFlag("crc off", 1'b0, crcEnable);
    scp_host_model_i.frame(16'h0000, 8);
    pins(1'b0, 1'b0);
    send(CMD_CLEAR);
    chkFlag("buffered", 1'b1, commErr);
    @(negedge clk) clkEn = 1'b0;
    repeat (4) @(negedge clk);
    clkEn = 1'b1;
    pins(1'b0, 1'b1);
    chkFlag("forwarded", 1'b0, commErr);
    pins(1'b0, 1'b0);
    send({OPC_READ, 5'h10});
    send(CMD_NOP);
    chkWord("remote held", resp(8'h01), scp_host_model_i.rx);
    pins(1'b0, 1'b1);
    send(CMD_NOP);
    chkWord("remote read", resp(8'h00), scp_host_model_i.rx);
    scp_host_model_i.frame({CMD_NOP, ~scp_host_model_i.crc8(8'hFF, CMD_NOP)}, 32);
    chkWord("daisy pass", {CMD_NOP, ~scp_host_model_i.crc8(8'hFF, CMD_NOP)}, scp_host_model_i.rx);
    chkFlag("daisy frame", 1'b0, commErr);
    chkFlag("regFaultLow", 1'b0, regFaultLow);
    chkFlag("regFaultHigh", 1'b0, regFaultHigh);
    chkFlag("safeStateReq", 1'b0, safeStateReq);
    summarize();
  end
endmodule
